// File: core/vcsu_core.sv
// Purpose: vertex outcode test and line colour clip unit
// Assumes: one clock, apb slave with zero wait states
// Notes: arithmetic is signed fixed point with FRAC bits
`timescale 1ns/1ps
`include "vcsu_defs.svh"
module vcsu_core
   import vcsu_pkg::*;
#(
   parameter int FRAC = 16 // fraction bits of operands
)(
   input wire logic mclk, // clock, 10 MHz
   input wire logic rst, // async reset, high
   input wire vcsu_apb_req_t apbReq, // apb request
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped
   output logic irq // interrupt level
);
   typedef enum {sIdle, sExec, sDiv, sColour} vcsu_state_t;

   ////////////////////////////////////////////////////////////
   // state
   logic signed [31:0] firstOperandFile_r [`VCSU_FILE_DEPTH];
   logic signed [31:0] firstOperandFile_nxt [`VCSU_FILE_DEPTH];
   logic signed [31:0] secondOperandFile_r [`VCSU_FILE_DEPTH];
   logic signed [31:0] secondOperandFile_nxt [`VCSU_FILE_DEPTH];
   logic signed [31:0] work_r, work_nxt;
   logic signed [31:0] tempHolding_r, tempHolding_nxt;
   logic signed [63:0] prod_r, prod_nxt;
   vcsu_flags_t flags_r, flags_nxt;
   vcsu_op_t op_r, op_nxt;
   vcsu_state_t state_r, state_nxt;
   logic [1:0] irqStat_r, irqStat_nxt;
   logic [1:0] irqEn_r, irqEn_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic [11:0] a;
   logic acc, wrAcc, busy, done, refuse, hit;
   logic outX, outY, outZ;
   logic [31:0] rdVal, flagWord;
   logic signed [31:0] gDiff;
   logic signed [63:0] quot;
   logic [1:0] clrMask;

   if (FRAC < 1 || FRAC > 30) begin : g_chk
      $error("vcsu_core: FRAC must lie in 1..30");
   end

   ////////////////////////////////////////////////////////////
   // helpers
   function automatic logic inFile(input logic [11:0] ad,
      input logic [11:0] base);
      return (ad[11:6] == base[11:6]) &&
         (ad[5:2] < `VCSU_FILE_DEPTH) && (ad[1:0] == 2'h0);
   endfunction : inFile

   // true when w minus the magnitude of c is negative
   function automatic logic outside(input logic signed [31:0] w,
      input logic signed [31:0] c);
      logic signed [32:0] mag;
      logic signed [32:0] diff;
      mag = c[31] ? -{c[31], c} : {c[31], c};
      diff = {w[31], w} - mag;
      return diff[32];
   endfunction : outside

   // fixed point product
   function automatic logic signed [31:0] fxMul(
      input logic signed [31:0] x, input logic signed [31:0] y);
      logic signed [63:0] p;
      p = x * y;
      return p[FRAC +: 32];
   endfunction : fxMul

   ////////////////////////////////////////////////////////////
   // bus decode and status views
   assign a = apbReq.paddr;
   assign acc = apbReq.psel && apbReq.penable;
   assign wrAcc = acc && apbReq.pwrite;
   assign busy = (state_r != sIdle);
   assign pready = 1'b1;
   assign pslverr = acc && !hit;
   assign prdata = prdata_r;
   assign irq = |(irqStat_r & irqEn_r);
   assign outX = outside(firstOperandFile_r[`VCSU_IX_W],
      firstOperandFile_r[`VCSU_IX_X]);
   assign outY = outside(firstOperandFile_r[`VCSU_IX_W],
      firstOperandFile_r[`VCSU_IX_Y]);
   assign outZ = outside(firstOperandFile_r[`VCSU_IX_W],
      firstOperandFile_r[`VCSU_IX_Z]);
   // divisor sits in second entry 9, a zero divisor gives zero
   assign quot = (secondOperandFile_r[`VCSU_IX_T9] == 32'sh0) ?
      64'sh0 : prod_r / 64'(secondOperandFile_r[`VCSU_IX_T9]);

   // read mux, status bits at their documented positions
   always_comb begin
      flagWord = `VCSU_RST_WORD;
      flagWord[`VCSU_BIT_XANY] = flags_r.xOutsideAnyFlag;
      flagWord[`VCSU_BIT_XALL] = flags_r.xOutsideAllFlag;
      flagWord[`VCSU_BIT_YANY] = flags_r.yOutsideAnyFlag;
      flagWord[`VCSU_BIT_YALL] = flags_r.yOutsideAllFlag;
      flagWord[`VCSU_BIT_ZANY] = flags_r.zOutsideAnyFlag;
      flagWord[`VCSU_BIT_ZALL] = flags_r.zOutsideAllFlag;
      flagWord[`VCSU_BIT_V] = flags_r.v;
      flagWord[`VCSU_BIT_Z] = flags_r.z;
      rdVal = `VCSU_RST_WORD;
      hit = 1'b1;
      if (a == `VCSU_ADDR_POLL)
         rdVal = busy ? `VCSU_POLL_BUSY : `VCSU_POLL_IDLE;
      else if (a == `VCSU_ADDR_FLAGS)
         rdVal = flagWord;
      else if (a == `VCSU_ADDR_ISTAT)
         rdVal = {30'h0, irqStat_r};
      else if (a == `VCSU_ADDR_IEN)
         rdVal = {30'h0, irqEn_r};
      else if (a == `VCSU_ADDR_WORK)
         rdVal = work_r;
      else if (a == `VCSU_ADDR_TEMP)
         rdVal = tempHolding_r;
      else if (a == `VCSU_ADDR_CMD || a == `VCSU_ADDR_ICLR)
         rdVal = `VCSU_RST_WORD;
      else if (inFile(a, `VCSU_BASE_FIRST))
         rdVal = firstOperandFile_r[a[5:2]];
      else if (inFile(a, `VCSU_BASE_SECOND))
         rdVal = secondOperandFile_r[a[5:2]];
      else
         hit = 1'b0;
   end

   ////////////////////////////////////////////////////////////
   // next state of the datapath, flags and bus registers
   always_comb begin
      firstOperandFile_nxt = firstOperandFile_r;
      secondOperandFile_nxt = secondOperandFile_r;
      work_nxt = work_r;
      tempHolding_nxt = tempHolding_r;
      prod_nxt = prod_r;
      flags_nxt = flags_r;
      op_nxt = op_r;
      state_nxt = state_r;
      irqEn_nxt = irqEn_r;
      done = 1'b0;
      refuse = 1'b0;
      gDiff = 32'sh0;
      prdata_nxt = prdata_r;
      // read data is captured in the setup cycle
      if (apbReq.psel && !apbReq.penable)
         prdata_nxt = rdVal;
      if (wrAcc && a == `VCSU_ADDR_IEN)
         irqEn_nxt = apbReq.pwdata[1:0];
      clrMask = (wrAcc && a == `VCSU_ADDR_ICLR) ?
         apbReq.pwdata[1:0] : `VCSU_RST_IRQ;
      // software writes to operands only while idle
      if (wrAcc && busy && a != `VCSU_ADDR_ICLR &&
         a != `VCSU_ADDR_IEN)
         refuse = 1'b1;
      else if (wrAcc) begin
         if (inFile(a, `VCSU_BASE_FIRST))
            firstOperandFile_nxt[a[5:2]] = apbReq.pwdata;
         else if (inFile(a, `VCSU_BASE_SECOND))
            secondOperandFile_nxt[a[5:2]] = apbReq.pwdata;
         else if (a == `VCSU_ADDR_WORK)
            work_nxt = apbReq.pwdata;
      end
      case (state_r)
         sIdle: begin
            if (wrAcc && a == `VCSU_ADDR_CMD) begin
               if (apbReq.pwdata[2:0] >= 3'(VERTEX_TEST_INIT_OP) &&
                  apbReq.pwdata[2:0] <= 3'(SECOND_COLOUR_CLIP_OP))
               begin
                  op_nxt = vcsu_op_t'(apbReq.pwdata[2:0]);
                  state_nxt = sExec;
               end else
                  refuse = 1'b1;
            end
         end
         sExec: begin
            case (op_r)
               VERTEX_TEST_INIT_OP: begin
                  flags_nxt.xOutsideAnyFlag = 1'b0;
                  flags_nxt.yOutsideAnyFlag = 1'b0;
                  flags_nxt.zOutsideAnyFlag = 1'b0;
                  flags_nxt.xOutsideAllFlag = 1'b1;
                  flags_nxt.yOutsideAllFlag = 1'b1;
                  flags_nxt.zOutsideAllFlag = 1'b1;
                  state_nxt = sIdle;
                  done = 1'b1;
               end
               VERTEX_TEST_OP: begin
                  secondOperandFile_nxt[`VCSU_IX_T9] =
                     firstOperandFile_r[`VCSU_IX_W];
                  if (outX)
                     flags_nxt.xOutsideAnyFlag = 1'b1;
                  else
                     flags_nxt.xOutsideAllFlag = 1'b0;
                  if (outY)
                     flags_nxt.yOutsideAnyFlag = 1'b1;
                  else
                     flags_nxt.yOutsideAllFlag = 1'b0;
                  if (outZ)
                     flags_nxt.zOutsideAnyFlag = 1'b1;
                  else
                     flags_nxt.zOutsideAllFlag = 1'b0;
                  flags_nxt.v = flags_nxt.xOutsideAllFlag ||
                     flags_nxt.yOutsideAllFlag ||
                     flags_nxt.zOutsideAllFlag;
                  flags_nxt.z = !(flags_nxt.xOutsideAnyFlag ||
                     flags_nxt.yOutsideAnyFlag ||
                     flags_nxt.zOutsideAnyFlag);
                  state_nxt = sIdle;
                  done = 1'b1;
               end
               FIRST_COLOUR_CLIP_OP: begin
                  // t from the work register times w2
                  prod_nxt = work_r *
                     secondOperandFile_r[`VCSU_IX_W];
                  secondOperandFile_nxt[`VCSU_IX_T9] =
                     firstOperandFile_r[`VCSU_IX_W];
                  firstOperandFile_nxt[`VCSU_IX_T8] =
                     secondOperandFile_r[`VCSU_IX_R] -
                     firstOperandFile_r[`VCSU_IX_R];
                  state_nxt = sDiv;
               end
               SECOND_COLOUR_CLIP_OP: begin
                  prod_nxt = work_r *
                     secondOperandFile_r[`VCSU_IX_WF];
                  secondOperandFile_nxt[`VCSU_IX_T9] =
                     firstOperandFile_r[`VCSU_IX_W];
                  firstOperandFile_nxt[`VCSU_IX_T8] =
                     firstOperandFile_r[`VCSU_IX_R] -
                     secondOperandFile_r[`VCSU_IX_R];
                  state_nxt = sDiv;
               end
               default: state_nxt = sIdle;
            endcase
         end
         sDiv: begin
            // corrected factor, product over clipped w
            work_nxt = quot[31:0];
            if (op_r == FIRST_COLOUR_CLIP_OP)
               firstOperandFile_nxt[`VCSU_IX_T9] =
                  secondOperandFile_r[`VCSU_IX_B] -
                  firstOperandFile_r[`VCSU_IX_B];
            else
               firstOperandFile_nxt[`VCSU_IX_T9] =
                  firstOperandFile_r[`VCSU_IX_B] -
                  secondOperandFile_r[`VCSU_IX_B];
            state_nxt = sColour;
         end
         sColour: begin
            tempHolding_nxt = work_r;
            if (op_r == FIRST_COLOUR_CLIP_OP) begin
               gDiff = secondOperandFile_r[`VCSU_IX_G] -
                  firstOperandFile_r[`VCSU_IX_G];
               firstOperandFile_nxt[`VCSU_IX_R] =
                  firstOperandFile_r[`VCSU_IX_R] + fxMul(
                  firstOperandFile_r[`VCSU_IX_T8], work_r);
               firstOperandFile_nxt[`VCSU_IX_B] =
                  firstOperandFile_r[`VCSU_IX_B] + fxMul(
                  firstOperandFile_r[`VCSU_IX_T9], work_r);
               firstOperandFile_nxt[`VCSU_IX_G] =
                  firstOperandFile_r[`VCSU_IX_G] +
                  fxMul(gDiff, work_r);
            end else begin
               gDiff = firstOperandFile_r[`VCSU_IX_G] -
                  secondOperandFile_r[`VCSU_IX_G];
               firstOperandFile_nxt[`VCSU_IX_R] =
                  secondOperandFile_r[`VCSU_IX_R] + fxMul(
                  firstOperandFile_r[`VCSU_IX_T8], work_r);
               firstOperandFile_nxt[`VCSU_IX_B] =
                  secondOperandFile_r[`VCSU_IX_B] + fxMul(
                  firstOperandFile_r[`VCSU_IX_T9], work_r);
               // green follows the second endpoint, as intended
               firstOperandFile_nxt[`VCSU_IX_G] =
                  secondOperandFile_r[`VCSU_IX_G] +
                  fxMul(gDiff, work_r);
            end
            firstOperandFile_nxt[`VCSU_IX_T8] = gDiff;
            state_nxt = sIdle;
            done = 1'b1;
         end
         default: state_nxt = sIdle;
      endcase
      // a new event wins over a clear in the same cycle
      irqStat_nxt = (irqStat_r & ~clrMask) | {refuse, done};
   end

   ////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < `VCSU_FILE_DEPTH; i++) begin
            firstOperandFile_r[i] <= `VCSU_RST_WORD;
            secondOperandFile_r[i] <= `VCSU_RST_WORD;
         end
         work_r <= `VCSU_RST_WORD;
         tempHolding_r <= `VCSU_RST_WORD;
         prod_r <= 64'sh0;
         flags_r <= '0;
         op_r <= NO_OP;
         state_r <= sIdle;
         irqStat_r <= `VCSU_RST_IRQ;
         irqEn_r <= `VCSU_RST_IRQ;
         prdata_r <= `VCSU_RST_WORD;
      end else begin
         firstOperandFile_r <= firstOperandFile_nxt;
         secondOperandFile_r <= secondOperandFile_nxt;
         work_r <= work_nxt;
         tempHolding_r <= tempHolding_nxt;
         prod_r <= prod_nxt;
         flags_r <= flags_nxt;
         op_r <= op_nxt;
         state_r <= state_nxt;
         irqStat_r <= irqStat_nxt;
         irqEn_r <= irqEn_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic vtxNow, initNow, startNow;
   assign vtxNow = (state_r == sExec) && (op_r == VERTEX_TEST_OP);
   assign initNow = (state_r == sExec) && (op_r == VERTEX_TEST_INIT_OP);
   assign startNow = !busy && wrAcc && a == `VCSU_ADDR_CMD &&
      (apbReq.pwdata[2:0] == 3'(FIRST_COLOUR_CLIP_OP) ||
      apbReq.pwdata[2:0] == 3'(SECOND_COLOUR_CLIP_OP));

   poll_value_a: assert property (
      apbReq.psel && !apbReq.penable && a == `VCSU_ADDR_POLL |=>
      prdata == ($past(busy) ? `VCSU_POLL_BUSY : `VCSU_POLL_IDLE))
      else $error("poll value wrong");
   x_any_a: assert property (vtxNow && outX |=>
      flags_r.xOutsideAnyFlag) else $error("x any not set");
   x_all_a: assert property (vtxNow && !outX |=>
      !flags_r.xOutsideAllFlag) else $error("x all not cleared");
   y_outcode_a: assert property (vtxNow |=>
      (flags_r.yOutsideAnyFlag == ($past(flags_r.yOutsideAnyFlag)
      || $past(outY)))) else $error("y any wrong");
   z_all_a: assert property (vtxNow && !outZ |=>
      !flags_r.zOutsideAllFlag) else $error("z all not cleared");
   v_flag_a: assert property (vtxNow |=> flags_r.v ==
      (flags_r.xOutsideAllFlag || flags_r.yOutsideAllFlag ||
      flags_r.zOutsideAllFlag)) else $error("v flag wrong");
   z_flag_a: assert property (vtxNow |=> flags_r.z ==
      !(flags_r.xOutsideAnyFlag || flags_r.yOutsideAnyFlag ||
      flags_r.zOutsideAnyFlag)) else $error("z flag wrong");
   verdict_valid_a: assert property (vtxNow |=>
      !(flags_r.v && flags_r.z)) else $error("verdict 11");
   vertex_temp_a: assert property (vtxNow |=>
      secondOperandFile_r[`VCSU_IX_T9] ==
      $past(firstOperandFile_r[`VCSU_IX_W])) else $error("temp");
   init_flags_a: assert property (initNow |=>
      flags_r[7:2] == 6'h15) else $error("init flags wrong");
   any_sticky_a: assert property ($fell(flags_r.xOutsideAnyFlag)
      |-> $past(initNow)) else $error("x any dropped");
   colour_busy_a: assert property (startNow |=>
      busy [*3] ##1 !busy) else $error("colour busy length");
   colour_factor_a: assert property (state_r == sColour |=>
      tempHolding_r == $past(work_r)) else $error("factor lost");

   cover_vertex_c: cover property (initNow ##[1:20] vtxNow);
   cover_first_c: cover property (startNow ##4 done == 1'b0);
   cover_refuse_c: cover property (busy && refuse);
   cover_irq_c: cover property ($rose(irq));
endmodule : vcsu_core

// File: common/vcsu_defs.svh
// Purpose: constants of the vertex clip status unit
// Assumes: apb byte addresses, 12-bit address bus
// Notes: operand entries are q16.16 fixed point by default
`ifndef VCSU_DEFS_SVH
`define VCSU_DEFS_SVH
`define VCSU_ADDR_CMD 12'h000
`define VCSU_ADDR_POLL 12'h004
`define VCSU_ADDR_FLAGS 12'h008
`define VCSU_ADDR_ISTAT 12'h00C
`define VCSU_ADDR_ICLR 12'h010
`define VCSU_ADDR_IEN 12'h014
`define VCSU_ADDR_WORK 12'h018
`define VCSU_ADDR_TEMP 12'h01C
`define VCSU_BASE_FIRST 12'h040
`define VCSU_BASE_SECOND 12'h080
`define VCSU_FILE_DEPTH 4'hA
`define VCSU_POLL_BUSY 32'hFFFF_FFFF
`define VCSU_POLL_IDLE 32'h0000_0000
`define VCSU_RST_WORD 32'h0000_0000
`define VCSU_RST_IRQ 2'h0
`define VCSU_IRQ_DONE 0
`define VCSU_IRQ_REFUSE 1
`define VCSU_IX_X 0
`define VCSU_IX_Y 1
`define VCSU_IX_Z 2
`define VCSU_IX_W 3
`define VCSU_IX_R 4
`define VCSU_IX_B 5
`define VCSU_IX_G 6
`define VCSU_IX_WF 7
`define VCSU_IX_T8 8
`define VCSU_IX_T9 9
`define VCSU_BIT_Z 2
`define VCSU_BIT_V 1
`define VCSU_BIT_XANY 5
`define VCSU_BIT_XALL 6
`define VCSU_BIT_YANY 7
`define VCSU_BIT_YALL 8
`define VCSU_BIT_ZANY 9
`define VCSU_BIT_ZALL 10
`endif

// File: common/vcsu_pkg.sv
// Purpose: types of the vertex clip status unit
// Assumes: constants come from vcsu_defs.svh
// Notes: operation codes are the command register values
package vcsu_pkg;
   // operation written to the command register
   typedef enum logic [2:0] {
      NO_OP = 3'h0,
      VERTEX_TEST_INIT_OP = 3'h1,
      VERTEX_TEST_OP = 3'h2,
      FIRST_COLOUR_CLIP_OP = 3'h3,
      SECOND_COLOUR_CLIP_OP = 3'h4
   } vcsu_op_t;
   // outcode and verdict flags
   typedef struct packed {
      logic xOutsideAnyFlag;
      logic xOutsideAllFlag;
      logic yOutsideAnyFlag;
      logic yOutsideAllFlag;
      logic zOutsideAnyFlag;
      logic zOutsideAllFlag;
      logic v;
      logic z;
   } vcsu_flags_t;
   // apb request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } vcsu_apb_req_t;
endpackage : vcsu_pkg

// File: test/vcsu_host_model.sv
// Purpose: apb host that issues unit operations
// Assumes: request held until pready is seen high at a rising edge
// Notes: waits that run out are counted in tmoCount
`timescale 1ns/1ps
`include "vcsu_defs.svh"
module vcsu_host_model
   import vcsu_pkg::*;
(
   input wire logic mclk, // clock
   output vcsu_apb_req_t apbReq, // request to the unit
   input wire logic [31:0] prdata, // read data
   input wire logic pready, // ready
   input wire logic pslverr // error
);
   int tmoCount = 0; // exhausted waits
   logic lastErr = 1'b0; // error flag of the last transfer
   initial apbReq = '0;
   ////////////////////////////////////////////////////////////////////////
   // one transfer: setup, then access until pready
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge mclk);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge mclk);
      apbReq.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (pready !== 1'b1) tmoCount++;
      q = prdata;
      lastErr = pslverr;
      apbReq <= '0;
   endtask : xfer
   // poll until idle, bounded
   task automatic wait_idle;
      logic [31:0] q;
      int n;
      n = 0;
      do begin
         xfer(1'b0, `VCSU_ADDR_POLL, 32'h0, q);
         n++;
      end while (q !== `VCSU_POLL_IDLE && n < 64);
      if (q !== `VCSU_POLL_IDLE) tmoCount++;
   endtask : wait_idle
   // operation issued once the unit polls idle, or after 64 polls that stay busy
   task automatic issue(input vcsu_op_t op);
      logic [31:0] q;
      wait_idle();
      xfer(1'b1, `VCSU_ADDR_CMD, {29'h0, op}, q);
   endtask : issue
endmodule : vcsu_host_model

// File: test/testbench.sv
// Purpose: self-checking bench of the vertex clip status unit
// Assumes: zero wait apb slave, q16.16 operands
// Notes: expected values worked out by hand from fixed point rules
`timescale 1ns/1ps
`include "vcsu_defs.svh"
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin fails++; \
   $display("MISMATCH at %0t got %h exp %h", $time, (g), (e)); end end
module testbench
   import vcsu_pkg::*;
;
   logic mclk; // clock
   logic rst; // reset
   vcsu_apb_req_t apbReq; // bus request
   logic [31:0] prdata; // read data
   logic pready; // ready
   logic pslverr; // error
   logic irq; // interrupt
   logic [31:0] q; // last read data
   int fails = 0; // mismatches
   int nTests = 0; // compares
   // vertices x,y,z,w from the top
   localparam logic [127:0] VIN = 128'h00010000_FFFF0000_00010000_00010000;
   localparam logic [127:0] VOX = 128'h00020000_00000000_00000000_00010000;
   localparam logic [127:0] VOY = 128'h00000000_FFFE0000_00000000_00010000;
   localparam logic [127:0] VOZ = 128'h00000000_00000000_00030000_00010000;
   ////////////////////////////////////////////////////////////////////////
   vcsu_core i_vcsu_core (.mclk(mclk), .rst(rst), .apbReq(apbReq),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
   vcsu_host_model i_vcsu_host_model (.mclk(mclk), .apbReq(apbReq),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   ////////////////////////////////////////////////////////////////////////
   // clock, 100 ns period
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // bus helpers
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      i_vcsu_host_model.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rdChk(input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] e);
      i_vcsu_host_model.xfer(1'b0, a, 32'h0, q);
      `CHK(q & m, e)
   endtask : rdChk
   // load one vertex and test it
   task automatic vtx(input logic [127:0] v);
      for (int i = 0; i < 4; i++) begin
         wr(`VCSU_BASE_FIRST + 12'(4 * i), v[127 - 32 * i -: 32]);
      end
      i_vcsu_host_model.issue(VERTEX_TEST_OP);
   endtask : vtx
   // one polygon of three vertices
   task automatic poly(input logic [127:0] a, b, c, input logic [31:0] e);
      i_vcsu_host_model.issue(VERTEX_TEST_INIT_OP);
      i_vcsu_host_model.wait_idle();
      rdChk(`VCSU_ADDR_FLAGS, 32'h0000_07E0, 32'h0000_0540);
      vtx(a);
      vtx(b);
      vtx(c);
      i_vcsu_host_model.wait_idle();
      rdChk(`VCSU_ADDR_FLAGS, 32'h0000_07E6, e);
      rdChk(`VCSU_BASE_SECOND + 12'h024, '1, 32'h0001_0000);
      $display("polygon done, flags %h", e);
   endtask : poly
   // verdict and end of run
   task automatic close_out;
      fails += i_vcsu_host_model.tmoCount;
      $display("compares %0d, mismatches %0d", nTests, fails);
      if (fails == 0 && nTests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out
   // watchdog against a hang
   initial begin
      repeat (40000) @(posedge mclk);
      fails++;
      close_out();
   end
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst = 1'b1;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      rdChk(`VCSU_ADDR_POLL, '1, `VCSU_POLL_IDLE);
      rdChk(`VCSU_ADDR_FLAGS, '1, 32'h0000_0000);
      `CHK(irq, 1'b0)
      i_vcsu_host_model.xfer(1'b0, 12'h030, 32'h0, q);
      `CHK(i_vcsu_host_model.lastErr, 1'b1)
      `CHK(q, 32'h0000_0000)
      $display("reset and map test done");
      poly(VIN, VIN, VIN, 32'h0000_0004);
      poly(VOX, VOX, VOX, 32'h0000_0062);
      poly(VIN, VOY, VOZ, 32'h0000_0280);
      poly(VOX, VIN, VIN, 32'h0000_0020);
      // interrupt raise, clear, mask and refusal
      wr(`VCSU_ADDR_ICLR, 32'h0000_0003);
      wr(`VCSU_ADDR_IEN, 32'h0000_0001);
      i_vcsu_host_model.issue(VERTEX_TEST_INIT_OP);
      i_vcsu_host_model.wait_idle();
      `CHK(irq, 1'b1)
      rdChk(`VCSU_ADDR_ISTAT, 32'h0000_0003, 32'h0000_0001);
      wr(`VCSU_ADDR_ICLR, 32'h0000_0001);
      @(negedge mclk);
      `CHK(irq, 1'b0)
      wr(`VCSU_ADDR_IEN, 32'h0000_0000);
      wr(`VCSU_ADDR_CMD, 32'h0000_0005);
      `CHK(i_vcsu_host_model.lastErr, 1'b0)
      rdChk(`VCSU_ADDR_ISTAT, 32'h0000_0003, 32'h0000_0002);
      `CHK(irq, 1'b0)
      wr(`VCSU_ADDR_IEN, 32'h0000_0002);
      @(negedge mclk);
      `CHK(irq, 1'b1)
      `CHK(pready, 1'b1)
      $display("interrupt test done");
      // first endpoint colour clip, t'=0.25
      wr(`VCSU_BASE_FIRST + 12'h00C, 32'h0002_0000);
      wr(`VCSU_BASE_SECOND + 12'h00C, 32'h0001_0000);
      wr(`VCSU_BASE_FIRST + 12'h010, 32'h0001_0000);
      wr(`VCSU_BASE_FIRST + 12'h014, 32'h0000_0000);
      wr(`VCSU_BASE_FIRST + 12'h018, 32'h0003_0000);
      wr(`VCSU_BASE_SECOND + 12'h010, 32'h0005_0000);
      wr(`VCSU_BASE_SECOND + 12'h014, 32'h0004_0000);
      wr(`VCSU_BASE_SECOND + 12'h018, 32'h0001_0000);
      wr(`VCSU_ADDR_WORK, 32'h0000_8000);
      i_vcsu_host_model.issue(FIRST_COLOUR_CLIP_OP);
      rdChk(`VCSU_ADDR_POLL, '1, `VCSU_POLL_BUSY);
      i_vcsu_host_model.wait_idle();
      rdChk(`VCSU_BASE_FIRST + 12'h010, '1, 32'h0002_0000);
      rdChk(`VCSU_BASE_FIRST + 12'h014, '1, 32'h0001_0000);
      rdChk(`VCSU_BASE_FIRST + 12'h018, '1, 32'h0002_8000);
      rdChk(`VCSU_ADDR_TEMP, '1, 32'h0000_4000);
      $display("first colour clip done");
      // second endpoint colour clip, t'=0.25
      wr(`VCSU_BASE_SECOND + 12'h01C, 32'h0001_0000);
      wr(`VCSU_ADDR_WORK, 32'h0000_8000);
      i_vcsu_host_model.issue(SECOND_COLOUR_CLIP_OP);
      i_vcsu_host_model.wait_idle();
      rdChk(`VCSU_BASE_FIRST + 12'h010, '1, 32'h0004_4000);
      rdChk(`VCSU_BASE_FIRST + 12'h014, '1, 32'h0003_4000);
      rdChk(`VCSU_BASE_FIRST + 12'h018, '1, 32'h0001_6000);
      rdChk(`VCSU_ADDR_TEMP, '1, 32'h0000_4000);
      $display("second colour clip done");
      close_out();
   end
endmodule : testbench
